// *** verilog/pst_top.sv ***
// Sync pulse qualification, blanking, pulldown and Manchester response frame.
// Assumes the sync comparator output is synchronous to pclk and that pclk is
// the internal oscillator; software reaches the settings over APB.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "pst_cfg.svh"

module pst_top #(
  parameter int unsigned BLANK500_CYC = `PST_BLANK500_NS / `PST_CLK_NS,
  parameter int unsigned QUAL_CYC = `PST_QUAL_NS / `PST_CLK_NS,
  parameter int unsigned MIN_SAMPLES = `PST_MIN_SAMPLES,
  parameter int unsigned LPF_RST_CYC = (`PST_LPF_RST_NS + `PST_CLK_NS - 1) / `PST_CLK_NS,
  parameter int unsigned PD_DLY_CYC = (`PST_PD_DLY_NS + `PST_CLK_NS - 1) / `PST_CLK_NS,
  parameter int unsigned PD_ON_CYC = (`PST_PD_ON_NS + `PST_CLK_NS - 1) / `PST_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pst_pkg::pst_apb_req_t apb_req,
  output pst_pkg::pst_apb_rsp_t apb_rsp,
  input wire logic sync_comp,
  output pst_pkg::pst_link_t link
);
  import pst_pkg::*;

  // ----------------------------------------
  // Derived counts
  // ----------------------------------------
  localparam int unsigned HALF125_CYC = `PST_BIT125_NS / (2 * `PST_CLK_NS);
  localparam int unsigned HALF190_CYC = `PST_BIT190_NS / (2 * `PST_CLK_NS);
  localparam int unsigned SLOT_CYC = `PST_SLOT_UNIT_NS / `PST_CLK_NS;
  localparam logic [23:0] TMAX = 24'hFFFFFF;

  // Refuse settings the 24-bit timer or 12-bit counters cannot hold.
  if (BLANK500_CYC >= 32'h00FF0000 || QUAL_CYC < 2 || QUAL_CYC > 32'h0000FFFF ||
      MIN_SAMPLES >= QUAL_CYC / 2 || MIN_SAMPLES > 32'h00000FFE ||
      LPF_RST_CYC > 32'h0000FFFF || PD_DLY_CYC + PD_ON_CYC > 32'h0000FFFF) begin : g_bad
    $error("pst_top: timing parameter out of range");
  end

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Serial CRC, data LSB first then three zero bits.
  function automatic logic [2:0] crc3(input logic [9:0] d, input logic w10);
    logic [2:0] c;
    logic [12:0] s;
    logic m;
    int i;
    c = 3'h7; // RULE_19
    s = w10 ? {3'h0, d} : {2'h0, 3'h0, d[7:0]}; // RULE_20
    for (i = 0; i < 13; i++) begin
      if (i < (w10 ? 13 : 11)) begin
        m = c[2];
        c = {c[1:0], (i < (w10 ? 10 : 8)) ? s[i] : 1'b0}; // RULE_20
        c = c ^ (m ? 3'h3 : 3'h0); // RULE_19
      end
    end
    crc3 = c; // RULE_21
  endfunction : crc3

  // Frame in send order from bit 0 upward.
  function automatic logic [14:0] build_frame(input logic [9:0] d, input logic w10, input logic crc);
    logic [14:0] f;
    logic [2:0] c;
    logic p;
    int i;
    int w;
    f = 15'h0000; // RULE_15
    c = crc3(d, w10);
    w = w10 ? 10 : 8;
    p = w10 ? ^d : ^d[7:0]; // RULE_18
    for (i = 0; i < 10; i++) begin
      if (i < w) begin
        f[2 + i] = d[i]; // RULE_16
      end
    end
    if (crc) begin // RULE_17
      f[2 + w] = c[2];
      f[3 + w] = c[1];
      f[4 + w] = c[0];
    end else begin
      f[2 + w] = p; // RULE_18
    end
    build_frame = f;
  endfunction : build_frame

  function automatic logic [3:0] frame_len(input logic w10, input logic crc);
    frame_len = 4'(2 + (w10 ? 10 : 8) + (crc ? 3 : 1)); // RULE_15
  endfunction : frame_len

  // ----------------------------------------
  // State
  // ----------------------------------------
  pst_st_t q;
  pst_st_t n;
  logic tick;
  logic wr;
  logic setup;
  logic mapped;
  logic [11:0] half_cyc;
  logic [23:0] slot_at;

  // Address decode feeds only the error answer; the read latch decodes paddr in its own case.
  always_comb begin
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    mapped = apb_req.paddr == `PST_OFS_CTRL || apb_req.paddr == `PST_OFS_SLOT ||
             apb_req.paddr == `PST_OFS_DATA || apb_req.paddr == `PST_OFS_STAT ||
             apb_req.paddr == `PST_OFS_FAIL;
  end

  // Every access completes in its first access cycle.
  always_comb begin
    apb_rsp.prdata = q.prdata;
    apb_rsp.pready = apb_req.psel && apb_req.penable;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  end

  // Current sink combines data modulation and the sync pulldown.
  always_comb begin
    link.mod_on = q.mod | q.pd; // RULE_01
    link.lpf_reset = q.lpf_rst;
    link.valid_sync = q.valid;
  end

  // Bit rate and slot start, both in clock cycles.
  always_comb begin
    half_cyc = q.ctrl[`PST_CTRL_BAUD] ? 12'(HALF190_CYC) : 12'(HALF125_CYC); // RULE_22
    slot_at = 24'(q.slot) * 24'(SLOT_CYC);
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // The half-rate divider paces sampling; the timer runs at full rate so the
  // reference point keeps the finer resolution.
  always_comb begin
    n = q;
    n.valid = 1'b0;
    n.div = ~q.div;
    tick = q.div; // RULE_02

    // Register writes and read capture.
    if (wr) begin
      case (apb_req.paddr)
        `PST_OFS_CTRL: n.ctrl = apb_req.pwdata[5:0];
        `PST_OFS_SLOT: n.slot = apb_req.pwdata[11:0];
        `PST_OFS_DATA: n.data = apb_req.pwdata[9:0];
        default: n.ctrl = q.ctrl;
      endcase
    end
    if (setup) begin
      case (apb_req.paddr)
        `PST_OFS_CTRL: n.prdata = {26'h0, q.ctrl};
        `PST_OFS_SLOT: n.prdata = {20'h00000, q.slot};
        `PST_OFS_DATA: n.prdata = {22'h0, q.data};
        `PST_OFS_STAT: n.prdata = {q.syncs, 10'h000, q.tx_done, q.lpf_rst, q.tx_busy, q.pd, q.state};
        `PST_OFS_FAIL: n.prdata = {16'h0000, q.fails};
        default: n.prdata = 32'h00000000;
      endcase
    end

    case (q.state)
      ST_IDLE: begin
        n.mod = 1'b0; // RULE_13
        n.pd = 1'b0;
        n.lpf_rst = 1'b0;
        n.tx_busy = 1'b0;
        if (q.ctrl[`PST_CTRL_EN] && tick && sync_comp) begin
          n.state = ST_QUAL;
          n.timer = 24'h000000; // RULE_04
          n.qcnt = 12'h001; // RULE_02
        end
      end
      ST_QUAL: begin
        n.timer = q.timer + 24'h000001; // RULE_04
        if (tick && sync_comp && q.qcnt != 12'hFFF) begin
          n.qcnt = q.qcnt + 12'h001; // RULE_02
        end
        if (q.timer >= 24'(QUAL_CYC - 1)) begin
          if (q.qcnt > 12'(MIN_SAMPLES)) begin // RULE_03
            n.state = ST_ACTIVE;
            n.valid = 1'b1; // RULE_05
            n.qcnt = 12'h000; // RULE_06
            n.syncs = q.syncs + 16'h0001;
            n.frame = build_frame(q.data, q.ctrl[`PST_CTRL_WLEN], q.ctrl[`PST_CTRL_CRC]);
            n.nbits = frame_len(q.ctrl[`PST_CTRL_WLEN], q.ctrl[`PST_CTRL_CRC]);
            n.tx_done = 1'b0;
            n.lpf_rst = 1'b1; // RULE_08
          end else begin
            n.state = ST_IDLE; // RULE_09
            n.timer = 24'h000000; // RULE_09
            n.qcnt = 12'h000;
            n.fails = q.fails + 16'h0001;
          end
        end
      end
      ST_ACTIVE: begin
        // Detection counter stays cleared; the comparator is ignored here.
        if (q.timer != TMAX) begin
          n.timer = q.timer + 24'h000001; // RULE_05
        end
        // Filter reset is counted from the valid pulse, so it keeps its full
        // length even when qualification takes longer than the reset time.
        n.lpf_rst = q.timer < 24'(QUAL_CYC + LPF_RST_CYC - 1); // RULE_08
        n.pd = q.ctrl[`PST_CTRL_PD] && q.timer >= 24'(PD_DLY_CYC - 1) &&
               q.timer < 24'(PD_DLY_CYC + PD_ON_CYC - 1); // RULE_11
        if (!q.tx_busy && !q.tx_done && q.timer >= slot_at) begin
          n.tx_busy = 1'b1; // RULE_10
          n.bit_idx = 4'h0;
          n.second = 1'b0;
          n.hcnt = 12'h000;
        end
        if (q.tx_busy) begin
          n.hcnt = q.hcnt + 12'h001; // RULE_22
          if (q.hcnt == half_cyc - 12'h001) begin
            n.hcnt = 12'h000;
            n.second = ~q.second;
            if (q.second) begin
              if (q.bit_idx == q.nbits - 4'h1) begin
                n.tx_busy = 1'b0;
                n.tx_done = 1'b1;
              end else begin
                n.bit_idx = q.bit_idx + 4'h1;
              end
            end
          end
        end
        // First half carries the bit, second half its inverse, so a zero is a
        // mid-bit rise and equal neighbours flip at their boundary.
        if (n.tx_busy) begin
          n.mod = n.second ? ~q.frame[n.bit_idx] : q.frame[n.bit_idx]; // RULE_12 RULE_14
        end else begin
          n.mod = 1'b0; // RULE_13
        end
        // Variable blanking ends exactly with the frame; the fixed option also
        // waits for the frame so a reply is never cut short.
        if (q.tx_done && (q.ctrl[`PST_CTRL_BLANK] || q.timer >= 24'(BLANK500_CYC))) begin // RULE_07
          n.state = ST_IDLE; // RULE_06
          n.timer = 24'h000000;
          n.pd = 1'b0;
          n.lpf_rst = 1'b0;
        end
      end
      default: begin
        n.state = ST_IDLE;
        n.timer = 24'h000000;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.ctrl <= `PST_CTRL_RST;
      q.slot <= `PST_SLOT_RST;
      q.data <= `PST_DATA_RST;
    end else begin
      q <= n;
    end
  end

endmodule : pst_top

// *** verilog/pst_cfg.svh ***
// Constants for the satellite sync detector and response transmitter.
// Assumes a single 250 MHz clock; times are in ns and pst_top turns them into cycles.
// How it works
// [RULE_01] Sync is voltage up; reply is current.
// [RULE_02] Qualification counter steps at half clock rate.
// [RULE_03] Sync valid when count exceeds minimum width.
// [RULE_04] Timers start at first comparator high sample.
// [RULE_05] Valid sync pulses, launches response timers.
// [RULE_06] Detection disabled for blanking after valid sync.
// [RULE_07] Blanking: fixed option, or slot plus frame.
// [RULE_08] Sync filter held in reset after sync.
// [RULE_09] Failed qualification resets timers, rearms immediately.
// [RULE_10] Transmit after programmed slot delay.
// [RULE_11] Optional pulldown after delay, for set duration.
// [RULE_12] Mid-bit rise means zero, fall means one.
// [RULE_13] Quiescent current, no modulation, between frames.
// [RULE_14] Equal bits get a boundary transition.
// [RULE_15] Frame: two start bits, word, check bits.
// [RULE_16] Data word sent least significant first.
// [RULE_17] Parity or 3-bit CRC by crc_select.
// [RULE_18] Parity makes count of ones even.
// [RULE_19] CRC polynomial x3+x+1, seed all ones.
// [RULE_20] CRC over data LSB first, three zeros.
// [RULE_21] CRC matches the ten-bit reference vectors.
// [RULE_22] Half-bit periods counted in clock cycles.
`ifndef PST_CFG_SVH
`define PST_CFG_SVH

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define PST_OFS_CTRL 8'h00
`define PST_OFS_SLOT 8'h04
`define PST_OFS_DATA 8'h08
`define PST_OFS_STAT 8'h0C
`define PST_OFS_FAIL 8'h10
`define PST_CTRL_EN 0
`define PST_CTRL_BLANK 1
`define PST_CTRL_WLEN 2
`define PST_CTRL_CRC 3
`define PST_CTRL_BAUD 4
`define PST_CTRL_PD 5
`define PST_CTRL_RST 6'h01
`define PST_SLOT_RST 12'h000
`define PST_DATA_RST 10'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define PST_CLK_NS 4
`define PST_BIT125_NS 8000
`define PST_BIT190_NS 5249
`define PST_SLOT_UNIT_NS 500
`define PST_BLANK500_NS 500000
`define PST_QUAL_NS 6000
`define PST_MIN_SAMPLES 400
`define PST_LPF_RST_NS 2000
`define PST_PD_DLY_NS 7000
`define PST_PD_ON_NS 6000

`endif

// *** verilog/pst_pkg.sv ***
// Types shared by the sync detector and response transmitter.
// Assumes APB with 8-bit byte addresses and 32-bit data.
package pst_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_QUAL = 2'b01,
    ST_ACTIVE = 2'b10
  } pst_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pst_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pst_apb_rsp_t;

  typedef struct packed {
    logic mod_on;
    logic lpf_reset;
    logic valid_sync;
  } pst_link_t;

  typedef struct packed {
    pst_state_t state;
    logic div;
    logic [5:0] ctrl;
    logic [11:0] slot;
    logic [9:0] data;
    logic [23:0] timer;
    logic [11:0] qcnt;
    logic tx_busy;
    logic tx_done;
    logic [3:0] bit_idx;
    logic [3:0] nbits;
    logic second;
    logic [11:0] hcnt;
    logic [14:0] frame;
    logic mod;
    logic pd;
    logic lpf_rst;
    logic valid;
    logic [15:0] syncs;
    logic [15:0] fails;
    logic [31:0] prdata;
  } pst_st_t;

endpackage : pst_pkg

// *** tb/pst_top_properties.sv ***
// Assertions on the ports of the sync detector and response transmitter.
// Assumes one pclk domain and single clean sync pulses from the bench.
`timescale 1ns/1ps
module pst_top_properties #(
  parameter int unsigned QUAL_CYC = 40,
  parameter int unsigned LPF_RST_CYC = 60
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pst_pkg::pst_apb_req_t apb_req,
  input wire pst_pkg::pst_apb_rsp_t apb_rsp,
  input wire logic sync_comp,
  input wire pst_pkg::pst_link_t link
);
  import pst_pkg::*;
  localparam int LPF_LO = LPF_RST_CYC - 1;
  localparam int LPF_HI = LPF_RST_CYC + 1;
  logic acc;
  logic [11:0] rise_q;
  logic [11:0] lpf_q;
  logic [11:0] high_q;
  assign acc = apb_req.psel && apb_req.penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // High run lengths; no saturation, since no level here stays up 4096 cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q <= 12'h000;
      lpf_q <= 12'h000;
      high_q <= 12'h000;
    end else begin
      rise_q <= sync_comp ? rise_q + 12'h001 : 12'h000;
      lpf_q <= link.lpf_reset ? lpf_q + 12'h001 : 12'h000;
      high_q <= link.mod_on ? high_q + 12'h001 : 12'h000;
    end
  end
  a_ready_no_wait: assert property (acc |-> apb_rsp.pready) else $error("pready missing");
  a_ready_idle_low: assert property (!acc |-> !apb_rsp.pready) else $error("pready outside access");
  a_unmapped_error: assert property (acc && apb_req.paddr > 8'h10 |-> apb_rsp.pslverr) else $error("no pslverr");
  a_valid_one_cycle: assert property (link.valid_sync |=> !link.valid_sync) else $error("long valid");
  a_valid_after_qual: assert property (
    link.valid_sync |-> sync_comp && rise_q >= QUAL_CYC - 1 && rise_q <= QUAL_CYC + 3) else $error("valid timing");
  a_lpf_follows_valid: assert property ($rose(link.valid_sync) |-> ##[0:1] link.lpf_reset)
    else $error("no filter reset");
  a_lpf_length: assert property ($fell(link.lpf_reset) |-> lpf_q >= LPF_LO && lpf_q <= LPF_HI)
    else $error("filter reset length");
  a_mod_high_run: assert property (link.mod_on |-> high_q <= 12'h7D1) else $error("no mid-bit edge");
endmodule : pst_top_properties

bind pst_top pst_top_properties #(.QUAL_CYC(QUAL_CYC), .LPF_RST_CYC(LPF_RST_CYC)) pst_top_properties_inst (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sync_comp(sync_comp), .link(link));

// *** tb/pst_master_model.sv ***
// Link master model: a sync shows as the comparator output going high.
// Assumes the comparator is synchronous to pclk.
`timescale 1ns/1ps
module pst_master_model (
  input wire logic pclk,
  output logic sync_comp
);
  initial sync_comp = 1'b0;
  // Raise the supply for cyc cycles; the reply is current, never seen here.
  task automatic pulse(input int cyc);
    @(posedge pclk);
    sync_comp <= 1'b1;
    repeat (cyc) @(posedge pclk);
    sync_comp <= 1'b0;
  endtask : pulse
endmodule : pst_master_model

// *** tb/testbench.sv ***
// Bench: APB set-up, syncs from the master model, frame decode on mod_on.
// Assumes shortened qualification, blanking and pulldown counts.
`timescale 1ns/1ps
module testbench;
  import pst_pkg::*;
  localparam int PDD = 150;
  localparam int PDO = 40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sync_comp;
  pst_apb_req_t apb_req = '0;
  pst_apb_rsp_t apb_rsp;
  pst_link_t link;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int vs = 0;
  pst_top #(.BLANK500_CYC(24000), .QUAL_CYC(40), .MIN_SAMPLES(10), .LPF_RST_CYC(60), .PD_DLY_CYC(PDD),
    .PD_ON_CYC(PDO)) pst_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .sync_comp(sync_comp), .link(link));
  pst_master_model pst_master_model_inst (.pclk(pclk), .sync_comp(sync_comp));
  always #2 pclk = ~pclk;
  // Count valid syncs; cut a hang short well past the planned run.
  always @(posedge pclk) begin
    cycles++;
    if (link.valid_sync === 1'b1) vs++;
    if (cycles == 100000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; the global cycle limit ends a missing pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk
  task automatic wait_mod(input logic v, output int n);
    n = 0;
    while (link.mod_on !== v) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_mod
  // A pulse of w cycles must give e valid syncs.
  task automatic sync(input int w, input int e);
    int v0;
    v0 = vs;
    pst_master_model_inst.pulse(w);
    repeat (40) @(posedge pclk);
    check(vs - v0, e);
  endtask : sync
  // Sync, then decode the reply: the first half of each bit carries it.
  task automatic frame(input logic [5:0] ctl, input logic [9:0] dat, input logic [14:0] exp, input int nb);
    logic [14:0] got;
    int h;
    int n;
    int t;
    int v0;
    int bad;
    h = ctl[4] ? 656 : 1000;
    t = 0;
    bad = 0;
    apb(1'b1, 8'h00, {26'h0, ctl});
    apb(1'b1, 8'h08, {22'h0, dat});
    sync(48, 1);
    v0 = vs;
    // A second sync in mid-frame falls in the blanking and is ignored.
    fork
      begin
        repeat (3000) @(posedge pclk);
        pst_master_model_inst.pulse(48);
      end
    join_none
    if (ctl[5]) begin
      wait_mod(1'b1, n);
      check(n >= PDD - 90 && n <= PDD - 80, 1);
      wait_mod(1'b0, t);
      check(t >= PDO - 2 && t <= PDO + 2, 1);
      t += n;
    end
    wait_mod(1'b1, n);
    check(t + n >= 285 + h && t + n <= 295 + h, 1);
    repeat (h / 2) @(posedge pclk);
    got = '0;
    got[0] = ~link.mod_on;
    for (int k = 1; k < nb; k++) begin
      repeat (h) @(posedge pclk);
      got[k] = link.mod_on;
      repeat (h) @(posedge pclk);
      bad += int'(link.mod_on !== ~got[k]);
    end
    check(bad, 0);
    check(got, exp);
    repeat (h) @(posedge pclk);
    check(link.mod_on, 0);
    check(vs - v0, 0);
  endtask : frame
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(8'h00, 32'h1);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rchk(8'h0C, 32'h0);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    check(err, 1);
    rchk(8'h14, 32'h0);
    check(err, 1);
    apb(1'b1, 8'h04, 32'h3);
    sync(8, 0);
    rchk(8'h10, 32'h1);
    // Eight-bit word, even parity, slow rate, pulldown on, blanking to frame end.
    frame(6'h23, 10'h0B5, {4'h0, ^8'hB5, 8'hB5, 2'b00}, 11);
    // Ten-bit words with CRC at the fast rate; C2 goes out first, so it sits lowest.
    frame(6'h1F, 10'h151, {3'b000, 10'h151, 2'b00}, 15);
    frame(6'h1D, 10'h3FF, {3'b001, 10'h3FF, 2'b00}, 15);
    sync(48, 0);
    repeat (4000) @(posedge pclk);
    sync(48, 1);
    rchk(8'h10, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd[31:16], 16'h4);
    complete_run();
  end
endmodule : testbench
